/* File: logic/crit_mask_pkg.sv */
// Package: command bytes, reset values and field positions for the mask bank
package crit_mask_pkg;

  localparam logic [7:0] CMD_CRIT_OUT_A_MASK    = 8'h0c;
  localparam logic [7:0] CMD_CRIT_OUT_B_MASK    = 8'h0d;
  localparam logic [7:0] CMD_DIODE_MODEL_STATUS = 8'h38;

  localparam logic [7:0] RST_CRIT_OUT_A_MASK = 8'h19;
  localparam logic [7:0] RST_CRIT_OUT_B_MASK = 8'h00;
  localparam logic [7:0] RST_DIODE_MODEL_STATUS = 8'h00;
  localparam logic [7:0] RST_READ_DATA          = 8'h00;

  // Five channels: bit 0 local, bits 1..4 remote 1..4
  localparam int         CHAN_COUNT = 5;
  localparam int         MASK_MSB   = 4;
  localparam int         REM_LSB    = 1;
  localparam logic [7:0] MASK_FIELD = 8'h1f;
  localparam logic [7:0] DIODE_FIELD = 8'h1e;

  localparam logic [7:0] TEMP_INIT  = 8'h00;
  localparam logic [7:0] LIMIT_INIT = 8'hff;

endpackage : crit_mask_pkg

/* File: logic/crit_event_tracker.sv */
// Per-channel hysteretic error event against a limit
`timescale 1ns/100ps
module crit_event_tracker (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Channel inputs
  input  wire logic       sample_valid,
  input  wire logic [7:0] reading,
  input  wire logic [7:0] limit,
  input  wire logic [4:0] hysteresis,
  // Event
  output logic            event_active
);

  logic [8:0] release_level;

  // Limit minus hysteresis; a borrow in bit 8 means no clear level
  assign release_level = {1'b0, limit} - {4'h0, hysteresis};

  // set at limit, clear below limit minus hysteresis
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_active <= 1'b0;
    end else if (sample_valid) begin
      if (reading >= limit) begin
        event_active <= 1'b1;
      end else if (!release_level[8] && ({1'b0, reading} < release_level)) begin
        event_active <= 1'b0;
      end
    end
  end

endmodule : crit_event_tracker

/* File: logic/crit_mask_bank.sv */
// Mask registers, diode model status and the two critical outputs
`timescale 1ns/100ps

// What this block does
// - Status bit n sets for remote n while beta compensation is on with a discrete diode, else clears.
// - The diode model status sits at command 0x38 and ignores writes.
// - Bits 7 to 5 of all three registers and bit 0 of the diode status read as zero.
// - The first output's mask is read/write at 0x0c and resets to 0x19.
// - A set mask bit blocks that channel's event from the first output; a clear bit passes it.
// - The second output's mask is read/write at 0x0d, resets to 0x00 and blocks on a set bit.
// - Mask bit 0 gates the local channel and bits 1 to 4 gate remote channels 1 to 4.
// - An output activates while any unmasked status bit is set and deactivates when all clear.
// - A status bit sets at reading at or above limit and clears below limit minus hysteresis.
module crit_mask_bank (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port from the serial interface
  input  wire logic [7:0] reg_cmd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Conversion results, one valid strobe per channel
  input  wire logic [4:0] sample_valid,
  input  wire logic [7:0] reading_local,
  input  wire logic [7:0] reading_rem1,
  input  wire logic [7:0] reading_rem2,
  input  wire logic [7:0] reading_rem3,
  input  wire logic [7:0] reading_rem4,
  // Limits per output for remotes 1 and 2, one limit for local and remotes 3 and 4, hysteresis shared
  input  wire logic [7:0] limit_a_local,
  input  wire logic [7:0] limit_a_rem1,
  input  wire logic [7:0] limit_a_rem2,
  input  wire logic [7:0] limit_b_rem1,
  input  wire logic [7:0] limit_b_rem2,
  input  wire logic [7:0] limit_rem3,
  input  wire logic [7:0] limit_rem4,
  input  wire logic [4:0] hysteresis,
  // Diode model detection, index 0 unused
  input  wire logic [4:0] beta_comp_on,
  input  wire logic [4:0] discrete_diode_seen,
  // Status readback and pins
  output logic      [4:0] status_a,
  output logic      [4:0] status_b,
  output logic            crit_out_a_n_o,
  output logic            crit_out_a_n_oe,
  output logic            crit_out_b_n_o,
  output logic            crit_out_b_n_oe
);

  // ============================================================
  // Registers
  // ============================================================
  logic [7:0] crit_out_a_mask;
  logic [7:0] crit_out_b_mask;
  logic [7:0] diode_model_status;
  logic [7:0] next_rdata;
  logic       next_a_active;
  logic       next_b_active;
  logic       wr_mask_a;
  logic       wr_mask_b;

  function automatic logic [7:0] mask_field(input logic [7:0] v);
    return v & crit_mask_pkg::MASK_FIELD;
  endfunction : mask_field

  function automatic logic gate_events(input logic [4:0] evts, input logic [7:0] mask);
    // Clear mask bit lets the event through
    return |(evts & ~mask[crit_mask_pkg::MASK_MSB:0]);
  endfunction : gate_events

  // ============================================================
  // Write decode
  // ============================================================
  // only the two mask commands take writes
  assign wr_mask_a = reg_wr && (reg_cmd == crit_mask_pkg::CMD_CRIT_OUT_A_MASK);
  assign wr_mask_b = reg_wr && (reg_cmd == crit_mask_pkg::CMD_CRIT_OUT_B_MASK);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crit_out_a_mask <= crit_mask_pkg::RST_CRIT_OUT_A_MASK;
    end else if (wr_mask_a) begin
      crit_out_a_mask <= mask_field(reg_wdata);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crit_out_b_mask <= crit_mask_pkg::RST_CRIT_OUT_B_MASK;
    end else if (wr_mask_b) begin
      crit_out_b_mask <= mask_field(reg_wdata);
    end
  end

  // ============================================================
  // Diode model status
  // ============================================================
  // diode model mismatch flags
  // no write path reaches this register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diode_model_status <= crit_mask_pkg::RST_DIODE_MODEL_STATUS;
    end else begin
      diode_model_status <= {3'h0, beta_comp_on[4:1] & discrete_diode_seen[4:1], 1'b0};
    end
  end

  // ============================================================
  // Read mux
  // ============================================================
  always_comb begin
    case (reg_cmd)
      crit_mask_pkg::CMD_CRIT_OUT_A_MASK:    next_rdata = mask_field(crit_out_a_mask);
      crit_mask_pkg::CMD_CRIT_OUT_B_MASK:    next_rdata = mask_field(crit_out_b_mask);
      crit_mask_pkg::CMD_DIODE_MODEL_STATUS:
        next_rdata = diode_model_status & crit_mask_pkg::DIODE_FIELD;
      default:                               next_rdata = 8'h00;
    endcase
  end

  // Read data one cycle after the command is presented
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= crit_mask_pkg::RST_READ_DATA;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ============================================================
  // Event trackers
  // ============================================================
  logic [7:0] readings [crit_mask_pkg::CHAN_COUNT];
  logic [7:0] limits_a [crit_mask_pkg::CHAN_COUNT];
  logic [7:0] limits_b [crit_mask_pkg::CHAN_COUNT];
  logic [4:0] event_a;
  logic [4:0] event_b;

  assign readings[0] = reading_local;
  assign readings[1] = reading_rem1;
  assign readings[2] = reading_rem2;
  assign readings[3] = reading_rem3;
  assign readings[4] = reading_rem4;
  // Remote 3, 4 and local share one limit across outputs
  assign limits_a[0] = limit_a_local;
  assign limits_a[1] = limit_a_rem1;
  assign limits_a[2] = limit_a_rem2;
  assign limits_a[3] = limit_rem3;
  assign limits_a[4] = limit_rem4;
  assign limits_b[0] = limit_a_local;
  assign limits_b[1] = limit_b_rem1;
  assign limits_b[2] = limit_b_rem2;
  assign limits_b[3] = limit_rem3;
  assign limits_b[4] = limit_rem4;

  for (genvar ch = 0; ch < crit_mask_pkg::CHAN_COUNT; ch++) begin : g_chan
    crit_event_tracker u_trk_a (
      .clk          (clk),
      .rst_n        (rst_n),
      .sample_valid (sample_valid[ch]),
      .reading      (readings[ch]),
      .limit        (limits_a[ch]),
      .hysteresis   (hysteresis),
      .event_active (event_a[ch])
    );
    crit_event_tracker u_trk_b (
      .clk          (clk),
      .rst_n        (rst_n),
      .sample_valid (sample_valid[ch]),
      .reading      (readings[ch]),
      .limit        (limits_b[ch]),
      .hysteresis   (hysteresis),
      .event_active (event_b[ch])
    );
  end

  // ============================================================
  // Status readback
  // ============================================================
  // Unmasked, so software still sees events that the pins hide
  assign status_a = event_a;
  assign status_b = event_b;

  // ============================================================
  // Outputs
  // ============================================================
  // bit n gates channel n
  assign next_a_active = gate_events(event_a, crit_out_a_mask);
  assign next_b_active = gate_events(event_b, crit_out_b_mask);

  // first pin pulled low while asserted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crit_out_a_n_oe <= 1'b0;
    end else begin
      crit_out_a_n_oe <= next_a_active;
    end
  end

  // second pin pulled low while asserted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crit_out_b_n_oe <= 1'b0;
    end else begin
      crit_out_b_n_oe <= next_b_active;
    end
  end

  // ============================================================
  // Pin drivers
  // ============================================================
  // Open drain: only ever pulls low, the board pull-up gives high
  assign crit_out_a_n_o = 1'b0;
  assign crit_out_b_n_o = 1'b0;

endmodule : crit_mask_bank

/* File: test/crit_mask_bank_assertions.sv */
// Port checker for the mask bank
`timescale 1ns/100ps
module crit_mask_bank_assertions (
  // Clock, reset, register port
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_cmd,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Events, diode inputs, pins
  input wire logic [4:0] beta_comp_on,
  input wire logic [4:0] discrete_diode_seen,
  input wire logic [4:0] status_a,
  input wire logic [4:0] status_b,
  input wire logic       crit_out_a_n_o,
  input wire logic       crit_out_b_n_o,
  input wire logic       crit_out_a_n_oe,
  input wire logic       crit_out_b_n_oe
);
  logic [4:0] ma;
  logic [4:0] mb;
  // Mask shadows, updated on accepted writes only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ma <= 5'h19;
      mb <= 5'h00;
    end else if (reg_wr && reg_cmd == 8'h0c) begin
      ma <= reg_wdata[4:0];
    end else if (reg_wr && reg_cmd == 8'h0d) begin
      mb <= reg_wdata[4:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  reserved_zero_a: assert property (reg_rdata[7:5] == 3'h0)
    else $error("reserved bits set");
  gate_out_a_a: assert property (crit_out_a_n_oe == $past(|(status_a & ~ma)))
    else $error("output a gating wrong");
  gate_out_b_a: assert property (crit_out_b_n_oe == $past(|(status_b & ~mb)))
    else $error("output b gating wrong");
  mask_a_read_a: assert property ($past(reg_cmd) == 8'h0c |-> reg_rdata == {3'h0, $past(ma)})
    else $error("mask a readback wrong");
  mask_b_read_a: assert property ($past(reg_cmd) == 8'h0d |-> reg_rdata == {3'h0, $past(mb)})
    else $error("mask b readback wrong");
  diode_read_a: assert property ($past(reg_cmd) == 8'h38 && $past(rst_n, 2) |->
    reg_rdata == {3'h0, $past(beta_comp_on[4:1] & discrete_diode_seen[4:1], 2), 1'b0})
    else $error("diode status wrong");
  unmapped_read_a: assert property (!($past(reg_cmd) inside {8'h0c, 8'h0d, 8'h38}) |->
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  pin_level_a: assert property (!crit_out_a_n_o && !crit_out_b_n_o)
    else $error("pin data not low");
endmodule : crit_mask_bank_assertions
bind crit_mask_bank crit_mask_bank_assertions i_chk (.clk(clk), .rst_n(rst_n),
  .reg_cmd(reg_cmd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .beta_comp_on(beta_comp_on), .discrete_diode_seen(discrete_diode_seen),
  .status_a(status_a), .status_b(status_b), .crit_out_a_n_o(crit_out_a_n_o),
  .crit_out_b_n_o(crit_out_b_n_o), .crit_out_a_n_oe(crit_out_a_n_oe),
  .crit_out_b_n_oe(crit_out_b_n_oe));

/* File: test/reg_host.sv */
// Host model driving the command port
`timescale 1ns/100ps
module reg_host (
  // Clock and read data
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  // Requests
  output logic      [7:0] reg_cmd,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_cmd = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_cmd = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // Released bus shows junk, not the old byte
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_cmd = a;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : reg_host

/* File: test/tb_top.sv */
// Testbench for the mask bank
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  int         failures = 0;
  int         checks = 0;
  logic [7:0] cmd, wdata, rdata, d;
  logic       wr, oa, ob, oea, oeb;
  logic [7:0] lim = 8'h50;
  logic [7:0] rdg [5] = '{default: 8'h00};
  logic [4:0] sv = 5'h00, hy = 5'h0a, beta = 5'h00, disc = 5'h00, sa, sb;
  always #10 clk = ~clk;
  crit_mask_bank i_crit_mask_bank (.clk(clk), .rst_n(rst_n), .reg_cmd(cmd), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rdata(rdata), .sample_valid(sv), .reading_local(rdg[0]),
    .reading_rem1(rdg[1]), .reading_rem2(rdg[2]), .reading_rem3(rdg[3]),
    .reading_rem4(rdg[4]), .limit_a_local(lim), .limit_a_rem1(lim), .limit_a_rem2(lim),
    .limit_b_rem1(lim), .limit_b_rem2(lim), .limit_rem3(lim), .limit_rem4(lim),
    .hysteresis(hy), .beta_comp_on(beta), .discrete_diode_seen(disc), .status_a(sa),
    .status_b(sb), .crit_out_a_n_o(oa), .crit_out_a_n_oe(oea), .crit_out_b_n_o(ob),
    .crit_out_b_n_oe(oeb));
  reg_host i_reg_host (.clk(clk), .reg_rdata(rdata), .reg_cmd(cmd), .reg_wr(wr),
    .reg_wdata(wdata));
  task automatic pulse(input int ch, input logic [7:0] r);
    @(negedge clk);
    rdg[ch] = r;
    sv = 5'h01 << ch;
    @(negedge clk);
    sv = 5'h00;
    repeat (2) @(negedge clk);
  endtask : pulse
  task automatic end_sim();
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    i_reg_host.rd(8'h0c, d);
    `CHK(d, 8'h19)
    i_reg_host.rd(8'h0d, d);
    `CHK(d, 8'h00)
    i_reg_host.wr(8'h0c, 8'hff);
    i_reg_host.rd(8'h0c, d);
    `CHK(d, 8'h1f)
    i_reg_host.wr(8'h38, 8'hff);
    i_reg_host.rd(8'h38, d);
    `CHK(d, 8'h00)
    i_reg_host.rd(8'h0d, d);
    `CHK(d, 8'h00)
    i_reg_host.rd(8'h21, d);
    `CHK(d, 8'h00)
    beta = 5'h1f;
    disc = 5'h0b;
    i_reg_host.rd(8'h38, d);
    `CHK(d, 8'h0a)
    for (int ch = 0; ch < 5; ch++) begin
      i_reg_host.wr(8'h0c, ~(8'h01 << ch));
      i_reg_host.wr(8'h0d, 8'h01 << ch);
      pulse(ch, lim);
      `CHK({oea, oeb, sa[ch], sb[ch]}, 4'hb)
      i_reg_host.wr(8'h0d, 8'h00);
      @(negedge clk);
      `CHK(oeb, 1'b1)
      pulse(ch, lim - {3'h0, hy});
      `CHK({oea, oeb, oa, ob}, 4'hc)
      i_reg_host.wr(8'h0c, 8'h1f);
      @(negedge clk);
      `CHK(oea, 1'b0)
      i_reg_host.wr(8'h0c, 8'h00);
      @(negedge clk);
      `CHK(oea, 1'b1)
      pulse(ch, lim - {3'h0, hy} - 8'h01);
      `CHK({oea, oeb, sa[ch], sb[ch]}, 4'h0)
    end
    end_sim();
  end
  // Run needs well under a thousand cycles
  initial begin
    #200us;
    failures++;
    end_sim();
  end
endmodule : tb_top
